//--- hw/rss_alu.v
// Purpose: Combinational datapath for the two carry rotates and the
//          literal-minus-working subtraction.
// Assumes: Operation code decoded by the caller from the command word.
// Notes:   Flags not touched by an operation are passed through unchanged.
`include "rss_exec_map.vh"

module rss_alu (
   // Operation and operands
   input  wire [2:0] op_i,
   input  wire [7:0] file_i,
   input  wire [7:0] work_i,
   input  wire [7:0] lit_i,
   // Flags in
   input  wire       carry_i,
   input  wire       nibble_i,
   input  wire       zero_i,
   // Result and flags out
   output reg  [7:0] result_o,
   output reg        carry_o,
   output reg        nibble_o,
   output reg        zero_o
);

   wire [8:0] diff;
   wire [4:0] low_diff;

   // RL8: two's complement difference.
   assign diff     = {1'b0, lit_i} - {1'b0, work_i};
   assign low_diff = {1'b0, lit_i[3:0]} - {1'b0, work_i[3:0]};

   always @* begin
      result_o = file_i;
      carry_o  = carry_i;
      nibble_o = nibble_i;
      zero_o   = zero_i;
      case (op_i)
         `RSS_OP_ROT_LEFT: begin
            // RL1: carry in, bit 7 out.
            result_o = {file_i[6:0], carry_i};
            carry_o  = file_i[7];
         end
         `RSS_OP_ROT_RIGHT: begin
            // RL2: carry in, bit 0 out.
            result_o = {carry_i, file_i[7:1]};
            carry_o  = file_i[0];
         end
         `RSS_OP_LIT_SUB: begin
            result_o = diff[7:0];
            // RL10: no borrow sets carry.
            carry_o  = ~diff[8];
            nibble_o = ~low_diff[4];
            // RL11: zero on zero difference.
            zero_o   = (diff[7:0] == 8'h00);
         end
         default: begin
            result_o = file_i;
         end
      endcase
   end

endmodule

//--- hw/rss_exec.v
// Purpose: Execution logic for rotate left and right through carry,
//          literal minus working register, and entry to the halt state.
// Assumes: One clock at 50 MHz; software issues operations through an
//          Avalon-MM slave with waitrequest; wake request arrives from a pin.
// Notes:   Every access answers on the second edge of the request; a write
//          to the command register executes on that edge.
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`include "rss_exec_map.vh"

// Notes on behaviour
// RL1: Left rotate through carry, bit 7 out.
// RL2: Right rotate through carry, bit 0 out.
// RL3: Destination 0 writes working, 1 writes file.
// RL4: Rotates take 7-bit address and destination bit.
// RL5: Halt clears watchdog counter and its prescaler.
// RL6: Halt clears power-down flag, sets time-out flag.
// RL7: Halt enters low-power state, stops oscillator.
// RL8: Subtract computes literal minus working, two's complement.
// RL9: Subtract writes working; updates carry, nibble, zero.
// RL10: Carry set when working not above literal.
// RL11: Zero set when difference is zero.
module rss_exec (
   // Clock, reset and enable
   input  wire        clk_sys_i,
   input  wire        reset_i,
   input  wire        clk_en_i,
   // Avalon-MM slave
   input  wire [7:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   input  wire [3:0]  avs_byteenable_i,
   output wire [31:0] avs_readdata_o,
   output wire        avs_waitrequest_o,
   // Wake request pin and halt outputs
   input  wire        wake_i,
   output wire        halted_o,
   output wire        osc_stop_o,
   output wire        wdog_clear_o
);

   localparam [1:0] ST_RUN  = 2'b01;
   localparam [1:0] ST_HALT = 2'b10;

   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg         ack_reg;
   reg  [31:0] rdata_reg;
   reg  [31:0] rdata_next;
   reg  [7:0]  work_reg;
   reg         carry_flag_reg;
   reg         nibble_carry_flag_reg;
   reg         zero_flag_reg;
   reg         halt_entered_flag_n_reg;
   reg         expiry_flag_n_reg;
   reg  [7:0]  watchdog_counter_reg;
   reg  [7:0]  presc_reg;
   reg         wdog_clear_reg;
   reg  [6:0]  file_sel_reg;
   reg         wake_meta_reg;
   reg         wake_sync_reg;
   reg         halted_reg;
   reg  [7:0]  file_mem [0:`RSS_FILE_DEPTH-1];

   wire [31:0] be_mask;
   wire [31:0] wdata;
   wire        req;
   wire        wr_take;
   wire        cmd_wr;
   wire [2:0]  cmd_op;
   wire [6:0]  cmd_addr;
   wire        cmd_dest;
   wire [7:0]  cmd_lit;
   wire        running;
   wire        exec_rot;
   wire        exec_sub;
   wire        exec_halt;
   wire [7:0]  alu_result;
   wire        alu_carry;
   wire        alu_nibble;
   wire        alu_zero;
   wire [7:0]  file_rd;
   wire [7:0]  sel_rd;
   wire        hit_cmd;
   wire        hit_work;
   wire        hit_status;
   wire        hit_sel;
   wire        hit_data;
   wire        rot_to_file;

   genvar gi;

   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
         assign be_mask[gi*8+7:gi*8] = {8{avs_byteenable_i[gi]}};
      end
   endgenerate

   assign wdata   = avs_writedata_i & be_mask;
   assign req     = avs_read_i | avs_write_i;
   // The answer comes one cycle after the request. The enable gates the
   // answer too, so the master never completes on an edge that is frozen.
   assign avs_waitrequest_o = req & ~(ack_reg & clk_en_i);
   assign avs_readdata_o    = rdata_reg;
   assign wr_take = avs_write_i & ack_reg & clk_en_i;
   assign cmd_wr  = wr_take & hit_cmd;

   // One decode per register keeps every write enable on the same compare.
   assign hit_cmd    = (avs_address_i == `RSS_OFS_CMD);
   assign hit_work   = (avs_address_i == `RSS_OFS_WORK);
   assign hit_status = (avs_address_i == `RSS_OFS_STATUS);
   assign hit_sel    = (avs_address_i == `RSS_OFS_FILE_SEL);
   assign hit_data   = (avs_address_i == `RSS_OFS_FILE_DATA);

   // RL4: seven-bit address, one destination bit.
   assign cmd_op   = wdata[`RSS_CMD_OP_MSB:`RSS_CMD_OP_LSB];
   assign cmd_addr = wdata[`RSS_CMD_ADDR_MSB:`RSS_CMD_ADDR_LSB];
   assign cmd_dest = wdata[`RSS_CMD_DEST_BIT];
   assign cmd_lit  = wdata[`RSS_CMD_LIT_MSB:`RSS_CMD_LIT_LSB];

   // Commands written while halted are dropped; the other register writes still land then.
   assign running   = (state_reg == ST_RUN);
   assign exec_rot  = cmd_wr & running &
                      ((cmd_op == `RSS_OP_ROT_LEFT) | (cmd_op == `RSS_OP_ROT_RIGHT));
   assign exec_sub  = cmd_wr & running & (cmd_op == `RSS_OP_LIT_SUB);
   assign exec_halt = cmd_wr & running & (cmd_op == `RSS_OP_HALT);
   assign rot_to_file = exec_rot & cmd_dest;

   assign file_rd = file_mem[cmd_addr];
   assign sel_rd  = file_mem[file_sel_reg];

   rss_alu u_alu (
      .op_i     (cmd_op),
      .file_i   (file_rd),
      .work_i   (work_reg),
      .lit_i    (cmd_lit),
      .carry_i  (carry_flag_reg),
      .nibble_i (nibble_carry_flag_reg),
      .zero_i   (zero_flag_reg),
      .result_o (alu_result),
      .carry_o  (alu_carry),
      .nibble_o (alu_nibble),
      .zero_o   (alu_zero)
   );

   // Bus acknowledge and read data capture.
   always @* begin
      rdata_next = 32'h00000000;
      case (avs_address_i)
         `RSS_OFS_WORK:      rdata_next[7:0] = work_reg;
         `RSS_OFS_STATUS: begin
            rdata_next[`RSS_ST_CARRY]     = carry_flag_reg;
            rdata_next[`RSS_ST_NIBBLE]    = nibble_carry_flag_reg;
            rdata_next[`RSS_ST_ZERO]      = zero_flag_reg;
            rdata_next[`RSS_ST_HALT_N]    = halt_entered_flag_n_reg;
            rdata_next[`RSS_ST_EXPIRY_N]  = expiry_flag_n_reg;
            rdata_next[`RSS_ST_HALTED]    = ~running;
         end
         `RSS_OFS_FILE_SEL:  rdata_next[6:0] = file_sel_reg;
         `RSS_OFS_FILE_DATA: rdata_next[7:0] = sel_rd;
         `RSS_OFS_WDOG:      rdata_next[15:0] = {presc_reg, watchdog_counter_reg};
         default:            rdata_next = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else if (clk_en_i) begin
         ack_reg <= req & ~ack_reg;
         if (avs_read_i & ~ack_reg) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // Wake pin synchroniser.
   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         wake_meta_reg <= 1'b0;
         wake_sync_reg <= 1'b0;
      end else if (clk_en_i) begin
         wake_meta_reg <= wake_i;
         wake_sync_reg <= wake_meta_reg;
      end
   end

   // Run and halt states.
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            // RL7: enter halt, oscillator stops.
            if (exec_halt) begin
               state_next = ST_HALT;
            end
         end
         ST_HALT: begin
            // Wake is looked at only here; a wake while running is ignored.
            if (wake_sync_reg) begin
               state_next = ST_RUN;
            end
         end
         default: state_next = ST_RUN;
      endcase
   end

   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= ST_RUN;
      end else if (clk_en_i) begin
         state_reg <= state_next;
      end
   end

   // Working register, flags and file selector.
   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         work_reg                <= `RSS_RST_WORK;
         {zero_flag_reg, nibble_carry_flag_reg, carry_flag_reg} <= `RSS_RST_FLAGS;
         halt_entered_flag_n_reg <= `RSS_RST_HALT_N;
         expiry_flag_n_reg       <= `RSS_RST_EXPIRY_N;
         file_sel_reg            <= 7'h00;
      end else if (clk_en_i) begin
         if (wr_take & hit_work) begin
            work_reg <= wdata[7:0];
         end
         if (wr_take & hit_status) begin
            carry_flag_reg        <= wdata[`RSS_ST_CARRY];
            nibble_carry_flag_reg <= wdata[`RSS_ST_NIBBLE];
            zero_flag_reg         <= wdata[`RSS_ST_ZERO];
         end
         if (wr_take & hit_sel) begin
            file_sel_reg <= wdata[6:0];
         end
         if (exec_rot) begin
            carry_flag_reg <= alu_carry;
            // RL3: destination 0 selects working.
            if (~cmd_dest) begin
               work_reg <= alu_result;
            end
         end
         // RL9: difference to working, three flags.
         if (exec_sub) begin
            work_reg              <= alu_result;
            carry_flag_reg        <= alu_carry;
            nibble_carry_flag_reg <= alu_nibble;
            zero_flag_reg         <= alu_zero;
         end
         // RL6: power-down cleared, time-out set.
         if (exec_halt) begin
            halt_entered_flag_n_reg <= 1'b0;
            expiry_flag_n_reg       <= 1'b1;
         end
      end
   end

   // File registers have no reset, like ordinary data memory.
   always @(posedge clk_sys_i) begin
      if (clk_en_i) begin
         // RL3: destination 1 writes the file.
         // Only one access is in flight, so a rotate and a bus write never meet.
         if (rot_to_file) begin
            file_mem[cmd_addr] <= alu_result;
         end else if (wr_take & hit_data) begin
            file_mem[file_sel_reg] <= wdata[7:0];
         end
      end
   end

   // Watchdog count mirror; it stands still while the oscillator is stopped.
   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         watchdog_counter_reg <= `RSS_WDOG_CLEAR;
         presc_reg            <= `RSS_PRESC_CLEAR;
         wdog_clear_reg       <= 1'b0;
      end else if (clk_en_i) begin
         wdog_clear_reg <= exec_halt;
         // RL5: clear counter and prescaler.
         if (exec_halt) begin
            watchdog_counter_reg <= `RSS_WDOG_CLEAR;
            presc_reg            <= `RSS_PRESC_CLEAR;
         end else if (running) begin
            presc_reg <= presc_reg + 8'h01;
            // The counter steps as the prescaler wraps from FF to 00.
            if (presc_reg == 8'hFF) begin
               watchdog_counter_reg <= watchdog_counter_reg + 8'h01;
            end
         end
      end
   end

   // The halt pins come from a flip-flop, so no decode glitch reaches them.
   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         halted_reg <= 1'b0;
      end else if (clk_en_i) begin
         halted_reg <= (state_next == ST_HALT);
      end
   end

   // RL7: oscillator stops with halt.
   assign halted_o     = halted_reg;
   assign osc_stop_o   = halted_reg;
   assign wdog_clear_o = wdog_clear_reg;

endmodule

//--- hw/rss_exec_map.vh
// Purpose: Register offsets, field positions, reset values and counts of the
//          rotate, subtract and halt execution block.
// Assumes: Registers sit on aligned 32-bit words of an Avalon-MM slave.
// Notes:   Byte addresses; narrower data sits in the low bits.
`ifndef RSS_EXEC_MAP_VH
`define RSS_EXEC_MAP_VH

// Register byte offsets.
`define RSS_OFS_CMD        8'h00
`define RSS_OFS_WORK       8'h04
`define RSS_OFS_STATUS     8'h08
`define RSS_OFS_FILE_SEL   8'h0C
`define RSS_OFS_FILE_DATA  8'h10
`define RSS_OFS_WDOG       8'h14

// Command word fields.
`define RSS_CMD_OP_LSB     0
`define RSS_CMD_OP_MSB     2
`define RSS_CMD_ADDR_LSB   8
`define RSS_CMD_ADDR_MSB   14
`define RSS_CMD_DEST_BIT   15
`define RSS_CMD_LIT_LSB    16
`define RSS_CMD_LIT_MSB    23

// Operation codes in the command word.
`define RSS_OP_NONE        3'h0
`define RSS_OP_ROT_LEFT    3'h1
`define RSS_OP_ROT_RIGHT   3'h2
`define RSS_OP_LIT_SUB     3'h3
`define RSS_OP_HALT        3'h4

// Status register bit positions.
`define RSS_ST_CARRY       0
`define RSS_ST_NIBBLE      1
`define RSS_ST_ZERO        2
`define RSS_ST_HALT_N      3
`define RSS_ST_EXPIRY_N    4
`define RSS_ST_HALTED      5

// Reset values.
`define RSS_RST_WORK       8'h00
`define RSS_RST_FLAGS      3'h0
`define RSS_RST_HALT_N     1'b1
`define RSS_RST_EXPIRY_N   1'b1
`define RSS_WDOG_CLEAR     8'h00
`define RSS_PRESC_CLEAR    8'h00

// Sizes.
`define RSS_FILE_DEPTH     128
`define RSS_FILE_AW        7

`endif

//--- test/rss_exec_checker.sv
// Purpose: Bus timing and halt entry checks for the execution block.
// Assumes: One clock domain; reset asynchronous, active high.
// Notes:   A halt command is a taken write of the halt code to CMD.
`include "rss_exec_map.vh"
module rss_exec_checker (
   // Clock, reset and enable
   input wire logic        clk_sys_i,
   input wire logic        reset_i,
   input wire logic        clk_en_i,
   // Bus
   input wire logic [7:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0]  avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   // Halt pins
   input wire logic        wake_i,
   input wire logic        halted_o,
   input wire logic        osc_stop_o,
   input wire logic        wdog_clear_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   logic req;
   logic halt_cmd;
   logic halt_cmd_q;
   assign req = avs_read_i | avs_write_i;
   assign halt_cmd = avs_write_i & ~avs_waitrequest_o & clk_en_i & avs_byteenable_i[0] & ~halted_o
      & (avs_address_i == `RSS_OFS_CMD) & (avs_writedata_i[2:0] == `RSS_OP_HALT);
   // Remembers a taken halt so a rise of the state can be traced to it.
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) halt_cmd_q <= 1'b0;
      else halt_cmd_q <= halt_cmd;
   end
   sequence s_halt;
      halt_cmd;
   endsequence
   sequence s_quiet;
      !wake_i ##1 !wake_i ##1 (!wake_i && halted_o);
   endsequence
   a_wait_one_cycle: assert property (req && avs_waitrequest_o && clk_en_i |=> !req || !avs_waitrequest_o)
      else $error("wait state longer than one cycle");
   a_wait_released: assert property (req && !avs_waitrequest_o && clk_en_i |=> avs_waitrequest_o || !req)
      else $error("answer held for more than one cycle");
   a_halt_enters: assert property (s_halt |=> halted_o)
      else $error("halt command did not enter halt");
   a_osc_with_halt: assert property (osc_stop_o == halted_o)
      else $error("oscillator stop differs from halt state");
   a_wdog_clear: assert property (s_halt |=> ##[0:1] wdog_clear_o)
      else $error("no watchdog clear after halt");
   a_clear_pulse: assert property (wdog_clear_o |=> !wdog_clear_o)
      else $error("watchdog clear longer than one cycle");
   a_halt_cause: assert property ($rose(halted_o) |-> halt_cmd_q)
      else $error("halt state entered without command");
   a_halt_holds: assert property (s_quiet |=> halted_o)
      else $error("halt state left without wake");
endmodule

bind rss_exec rss_exec_checker i_chk (.*);

//--- test/test_rotate_subtract_sleep_exec.sv
// Purpose: Random and corner tests of rotates, subtract and halt.
// Assumes: Clock enable held high; all byte lanes enabled.
// Notes:   Expected values come from the bench's own functions.
`include "rss_exec_map.vh"
module test_rotate_subtract_sleep_exec;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_i, reset_i, avs_read_i, avs_write_i, wake_i;
   logic        avs_waitrequest_o, halted_o, osc_stop_o, wdog_clear_o;
   logic [7:0]  avs_address_i, w, fv, lit, r;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic [6:0]  a;
   logic [2:0]  op;
   logic        c, nib, z, d;
   int          errors, cmp_count, k;

   rss_exec i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(1'b1),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .wake_i(wake_i), .halted_o(halted_o), .osc_stop_o(osc_stop_o),
      .wdog_clear_o(wdog_clear_o));

   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task report_and_stop;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // One bus access; the request stands until waitrequest is seen low.
   task xfer(input logic wr, input logic [7:0] ad, input logic [31:0] dt);
      int n;
      n = 0;
      avs_address_i <= ad;
      avs_writedata_i <= dt;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20);
      rd = avs_readdata_o;
      if (avs_waitrequest_o !== 1'b0) begin
         errors++;
         report_and_stop;
      end
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   function logic [8:0] f_rot(input logic l, input logic [7:0] v, input logic ci);
      return l ? {v, ci} : {v[0], ci, v[7:1]};
   endfunction

   function logic [10:0] f_sub(input logic [7:0] kv, input logic [7:0] wv);
      logic [7:0] s;
      s = kv - wv;
      return {wv <= kv, wv[3:0] <= kv[3:0], s == 8'h00, s};
   endfunction

   initial begin
      reset_i = 1'b1;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 8'h00;
      avs_writedata_i = 32'h0;
      wake_i = 1'b0;
      errors = 0;
      cmp_count = 0;
      void'($urandom(32'h861A));
      repeat (6) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      xfer(0, `RSS_OFS_WORK, 0);
      chk("work", 32'h0, rd);
      xfer(0, `RSS_OFS_STATUS, 0);
      chk("status", 32'h18, rd);
      xfer(1, 8'h40, 32'hFF);
      xfer(0, 8'h40, 0);
      chk("unmapped", 32'h0, rd);
      for (int i = 0; i < 60; i++) begin
         a = 7'($urandom_range(127));
         fv = 8'($urandom);
         w = 8'($urandom);
         lit = 8'($urandom);
         {z, nib, c} = 3'($urandom);
         d = 1'($urandom);
         op = 3'($urandom);
         if (op == `RSS_OP_HALT) op = `RSS_OP_LIT_SUB;
         // Equal, zero and borrow corners of the subtraction come first.
         if (i < 4) begin
            op = `RSS_OP_LIT_SUB;
            lit = i[1] ? 8'h00 : 8'h5A;
            w = i[0] ? lit : 8'hFF;
         end
         xfer(1, `RSS_OFS_FILE_SEL, {25'h0, a});
         xfer(1, `RSS_OFS_FILE_DATA, {24'h0, fv});
         xfer(1, `RSS_OFS_WORK, {24'h0, w});
         xfer(1, `RSS_OFS_STATUS, {29'h0, z, nib, c});
         xfer(1, `RSS_OFS_CMD, {8'h00, lit, d, a, 5'h00, op});
         case (op)
            `RSS_OP_ROT_LEFT, `RSS_OP_ROT_RIGHT: begin
               {c, r} = f_rot(op == `RSS_OP_ROT_LEFT, fv, c);
               if (d) fv = r;
               else w = r;
            end
            `RSS_OP_LIT_SUB: {c, nib, z, w} = f_sub(lit, w);
            default: ;
         endcase
         xfer(0, `RSS_OFS_WORK, 0);
         chk("work", {24'h0, w}, rd);
         xfer(0, `RSS_OFS_STATUS, 0);
         chk("flags", {29'h0, z, nib, c}, {29'h0, rd[2:0]});
         xfer(0, `RSS_OFS_FILE_DATA, 0);
         chk("file", {24'h0, fv}, rd);
      end
      xfer(1, `RSS_OFS_CMD, {29'h0, `RSS_OP_HALT});
      chk("halted", 32'h1, {31'h0, halted_o});
      chk("osc_stop", 32'h1, {31'h0, osc_stop_o});
      xfer(0, `RSS_OFS_WDOG, 0);
      chk("wdog", 32'h0, rd);
      xfer(0, `RSS_OFS_STATUS, 0);
      chk("status", {26'h0, 3'b110, z, nib, c}, rd);
      xfer(1, `RSS_OFS_CMD, {29'h0, `RSS_OP_ROT_LEFT});
      xfer(0, `RSS_OFS_WORK, 0);
      chk("work", {24'h0, w}, rd);
      wake_i <= 1'b1;
      k = 0;
      while (halted_o !== 1'b0 && k < 10) begin
         @(posedge clk_sys_i);
         k++;
      end
      chk("wake", 32'h0, {31'h0, halted_o});
      wake_i <= 1'b0;
      report_and_stop;
   end
endmodule
